//--- hdl/rlar_bank_if.sv
`timescale 1ns/10ps
interface rlar_bank_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic fc_load;
   logic [1:0] fc_gpio;
   logic fc_id_load;
   logic [6:0] fc_id;
   logic [7:0] bcc_byte;
   logic [7:0] ctl1_byte;
   logic [7:0] ctl2_byte;
   logic [7:0] id_byte;
   logic [7:0] alias_byte;
   logic [7:0] tgt0_byte;
   logic [7:0] talias0_byte;
   modport ctrl (output wr_en, wr_addr, wr_data, fc_load, fc_gpio, fc_id_load, fc_id,
      input bcc_byte, ctl1_byte, ctl2_byte, id_byte, alias_byte, tgt0_byte, talias0_byte);
   modport bank (input wr_en, wr_addr, wr_data, fc_load, fc_gpio, fc_id_load, fc_id,
      output bcc_byte, ctl1_byte, ctl2_byte, id_byte, alias_byte, tgt0_byte, talias0_byte);
endinterface

//--- hdl/rlar_pkg.sv
// Operation
// - Every register here except port select exists per receive port; port select picks the copy.
// - Override set: link data no longer loads datapath control, local values kept.
// - Override clear, its reset state: link data may load datapath control.
// - GPIO count code: 00 none, 01 one, 10 two, 11 four.
// - GPIO count loads from link; local write accepted only while override is 1.
// - Remote serializer identity loads automatically from forward channel data.
// - Hold bit set stops identity auto-load, keeping the locally written value.
// - Each transaction address is compared with the seven-bit remote alias.
// - Alias match replaces the address with the target address register value.
// - Remote alias of zero disables the decoder; nothing forwarded through it.
// - Auto-acknowledge set: every write aimed at remote serializer is acknowledged.
// - Target alias slot zero hit substitutes physical target address zero.
// - Forwarding on a decode match needs the per-port pass-through bit set.
package rlar_pkg;
   localparam logic [7:0] RLAR_PORT_SEL_OFS = 8'h4c;
   localparam logic [7:0] RLAR_BCC_OFS = 8'h58;
   localparam logic [7:0] RLAR_CTL1_OFS = 8'h59;
   localparam logic [7:0] RLAR_CTL2_OFS = 8'h5a;
   localparam logic [7:0] RLAR_ID_OFS = 8'h5b;
   localparam logic [7:0] RLAR_ALIAS_OFS = 8'h5c;
   localparam logic [7:0] RLAR_TGT0_OFS = 8'h5d;
   localparam logic [7:0] RLAR_TALIAS0_OFS = 8'h65;
   localparam int RLAR_OVR_BIT = 7;
   localparam int RLAR_PASS_BIT = 6;
   localparam logic [7:0] RLAR_BYTE_RST = 8'h00;
   localparam logic [6:0] RLAR_ADDR_RST = 7'h00;
   localparam logic [1:0] RLAR_GPIO_RST = 2'h0;
   localparam logic [4:0] RLAR_RSV_RST = 5'h00;

   function automatic logic rlar_addr_match(input logic [6:0] addr, input logic [6:0] alias_addr);
      rlar_addr_match = (alias_addr != 7'h00) && (addr == alias_addr);
   endfunction
endpackage

//--- hdl/rlar_port_bank.sv
`timescale 1ns/10ps
module rlar_port_bank
   import rlar_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   rlar_bank_if.bank bus
);
   logic pass_ff;
   logic override_ff;
   logic [4:0] ctl1_rsv_ff;
   logic [1:0] gpio_ff;
   logic [7:0] ctl2_ff;
   logic [6:0] id_ff;
   logic hold_ff;
   logic [6:0] alias_ff;
   logic auto_ack_ff;
   logic [6:0] tgt0_ff;
   logic [6:0] talias0_ff;

   wire wr_bcc = bus.wr_en && (bus.wr_addr == RLAR_BCC_OFS);
   wire wr_ctl1 = bus.wr_en && (bus.wr_addr == RLAR_CTL1_OFS);
   wire wr_ctl2 = bus.wr_en && (bus.wr_addr == RLAR_CTL2_OFS);
   wire wr_id = bus.wr_en && (bus.wr_addr == RLAR_ID_OFS);
   wire wr_alias = bus.wr_en && (bus.wr_addr == RLAR_ALIAS_OFS);
   wire wr_tgt0 = bus.wr_en && (bus.wr_addr == RLAR_TGT0_OFS);
   wire wr_talias0 = bus.wr_en && (bus.wr_addr == RLAR_TALIAS0_OFS);
   // Link load only while not overridden, local write only while overridden
   wire fc_gpio_take = bus.fc_load && !override_ff;
   wire loc_gpio_take = wr_ctl1 && override_ff;
   wire [1:0] nxt_gpio = fc_gpio_take ? bus.fc_gpio :
      (loc_gpio_take ? bus.wr_data[1:0] : gpio_ff);
   // Link identity wins over a same-cycle local write unless held
   wire fc_id_take = bus.fc_id_load && !hold_ff;
   wire [6:0] nxt_id = fc_id_take ? bus.fc_id : (wr_id ? bus.wr_data[7:1] : id_ff);

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pass_ff <= 1'b0;
         override_ff <= 1'b0;
         ctl1_rsv_ff <= RLAR_RSV_RST;
         gpio_ff <= RLAR_GPIO_RST;
         ctl2_ff <= RLAR_BYTE_RST;
         id_ff <= RLAR_ADDR_RST;
         hold_ff <= 1'b0;
         alias_ff <= RLAR_ADDR_RST;
         auto_ack_ff <= 1'b0;
         tgt0_ff <= RLAR_ADDR_RST;
         talias0_ff <= RLAR_ADDR_RST;
      end
      else
      begin
         if (wr_bcc)
            pass_ff <= bus.wr_data[RLAR_PASS_BIT];
         if (wr_ctl1)
         begin
            override_ff <= bus.wr_data[RLAR_OVR_BIT];
            ctl1_rsv_ff <= bus.wr_data[6:2];
         end
         gpio_ff <= nxt_gpio;
         if (wr_ctl2)
            ctl2_ff <= bus.wr_data;
         id_ff <= nxt_id;
         if (wr_id)
            hold_ff <= bus.wr_data[0];
         if (wr_alias)
         begin
            alias_ff <= bus.wr_data[7:1];
            auto_ack_ff <= bus.wr_data[0];
         end
         if (wr_tgt0)
            tgt0_ff <= bus.wr_data[7:1];
         if (wr_talias0)
            talias0_ff <= bus.wr_data[7:1];
      end
   end

   assign bus.bcc_byte = {1'b0, pass_ff, 6'h00};
   assign bus.ctl1_byte = {override_ff, ctl1_rsv_ff, gpio_ff};
   assign bus.ctl2_byte = ctl2_ff;
   assign bus.id_byte = {id_ff, hold_ff};
   assign bus.alias_byte = {alias_ff, auto_ack_ff};
   assign bus.tgt0_byte = {tgt0_ff, 1'b0};
   assign bus.talias0_byte = {talias0_ff, 1'b0};
endmodule

//--- hdl/rlar_top.sv
`timescale 1ns/10ps
module rlar_top
   import rlar_pkg::*;
#(
   parameter int NPORTS = 2
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic fc_load,
   input wire logic [$clog2(NPORTS)-1:0] fc_port,
   input wire logic [1:0] fc_gpio_count,
   input wire logic fc_id_load,
   input wire logic [6:0] fc_id,
   input wire logic i2c_req,
   input wire logic [$clog2(NPORTS)-1:0] i2c_port,
   input wire logic [7:0] i2c_first_byte,
   output logic fwd_valid,
   output logic [7:0] fwd_byte,
   output logic fwd_auto_ack,
   output logic [2*NPORTS-1:0] link_gpio_count
);
   localparam int PW = $clog2(NPORTS);

   if (NPORTS < 2 || NPORTS > 4)
   begin : gen_bad_nports
      $error("NPORTS must be 2 to 4");
   end

   logic [7:0] port_sel_ff;
   logic [7:0] rdata_ff;
   logic fwd_valid_ff;
   logic [7:0] fwd_byte_ff;
   logic fwd_auto_ack_ff;

   logic [7:0] bcc_a [NPORTS];
   logic [7:0] ctl1_a [NPORTS];
   logic [7:0] ctl2_a [NPORTS];
   logic [7:0] id_a [NPORTS];
   logic [7:0] alias_a [NPORTS];
   logic [7:0] tgt0_a [NPORTS];
   logic [7:0] talias0_a [NPORTS];

   wire [PW-1:0] sel_port = port_sel_ff[PW-1:0];
   wire sel_ok = (port_sel_ff[7:PW] == '0) && (int'(sel_port) < NPORTS);
   wire wr_port_sel = reg_wr && (reg_addr == RLAR_PORT_SEL_OFS);

   rlar_bank_if bif [NPORTS] ();

   for (genvar g = 0; g < NPORTS; g++)
   begin : gen_port
      // Local access reaches only the selected port's copy
      assign bif[g].wr_en = reg_wr && sel_ok && (sel_port == PW'(g));
      assign bif[g].wr_addr = reg_addr;
      assign bif[g].wr_data = reg_wdata;
      assign bif[g].fc_load = fc_load && (fc_port == PW'(g));
      assign bif[g].fc_gpio = fc_gpio_count;
      assign bif[g].fc_id_load = fc_id_load && (fc_port == PW'(g));
      assign bif[g].fc_id = fc_id;
      assign bcc_a[g] = bif[g].bcc_byte;
      assign ctl1_a[g] = bif[g].ctl1_byte;
      assign ctl2_a[g] = bif[g].ctl2_byte;
      assign id_a[g] = bif[g].id_byte;
      assign alias_a[g] = bif[g].alias_byte;
      assign tgt0_a[g] = bif[g].tgt0_byte;
      assign talias0_a[g] = bif[g].talias0_byte;
      assign link_gpio_count[2*g+1:2*g] = bif[g].ctl1_byte[1:0];
      rlar_port_bank u_bank (
         .core_clk(core_clk),
         .rst_b(rst_b),
         .bus(bif[g])
      );
   end

   // Read selection for the chosen port
   logic [7:0] port_rd;
   always_comb
   begin
      port_rd = 8'h00;
      if (sel_ok)
      begin
         case (reg_addr)
            RLAR_BCC_OFS: port_rd = bcc_a[sel_port];
            RLAR_CTL1_OFS: port_rd = ctl1_a[sel_port];
            RLAR_CTL2_OFS: port_rd = ctl2_a[sel_port];
            RLAR_ID_OFS: port_rd = id_a[sel_port];
            RLAR_ALIAS_OFS: port_rd = alias_a[sel_port];
            RLAR_TGT0_OFS: port_rd = tgt0_a[sel_port];
            RLAR_TALIAS0_OFS: port_rd = talias0_a[sel_port];
            default: port_rd = 8'h00;
         endcase
      end
   end
   wire [7:0] nxt_rdata = (reg_addr == RLAR_PORT_SEL_OFS) ? port_sel_ff : port_rd;

   // Address decode on the requesting port
   wire [6:0] req_addr = i2c_first_byte[7:1];
   wire req_rw = i2c_first_byte[0];
   wire [6:0] req_alias = alias_a[i2c_port][7:1];
   wire [6:0] req_talias = talias0_a[i2c_port][7:1];
   wire [6:0] req_tgt0 = tgt0_a[i2c_port][7:1];
   wire req_pass = bcc_a[i2c_port][RLAR_PASS_BIT];
   wire req_auto = alias_a[i2c_port][0];
   wire ser_hit = rlar_addr_match(req_addr, req_alias);
   wire tgt_hit = rlar_addr_match(req_addr, req_talias);
   wire any_hit = ser_hit || tgt_hit;
   // Port beyond the bank count never decodes
   wire req_port_ok = int'(i2c_port) < NPORTS;
   wire nxt_fwd_valid = i2c_req && req_port_ok && any_hit && req_pass;
   wire [7:0] nxt_fwd_byte = {req_tgt0, req_rw};
   wire nxt_auto_ack = i2c_req && req_port_ok && ser_hit && !req_rw && req_auto;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         port_sel_ff <= RLAR_BYTE_RST;
         rdata_ff <= RLAR_BYTE_RST;
         fwd_valid_ff <= 1'b0;
         fwd_byte_ff <= RLAR_BYTE_RST;
         fwd_auto_ack_ff <= 1'b0;
      end
      else
      begin
         if (wr_port_sel)
            port_sel_ff <= reg_wdata;
         if (reg_rd)
            rdata_ff <= nxt_rdata;
         fwd_valid_ff <= nxt_fwd_valid;
         if (nxt_fwd_valid)
            fwd_byte_ff <= nxt_fwd_byte;
         fwd_auto_ack_ff <= nxt_auto_ack;
      end
   end

   assign reg_rdata = rdata_ff;
   assign fwd_valid = fwd_valid_ff;
   assign fwd_byte = fwd_byte_ff;
   assign fwd_auto_ack = fwd_auto_ack_ff;
endmodule

//--- tb/rlar_checker.sv
`timescale 1ns/10ps
module rlar_checker
#(
   parameter int NPORTS = 2
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic fc_load,
   input wire logic i2c_req,
   input wire logic [7:0] i2c_first_byte,
   input wire logic fwd_valid,
   input wire logic [7:0] fwd_byte,
   input wire logic fwd_auto_ack,
   input wire logic [2*NPORTS-1:0] link_gpio_count
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   AST_FWD_CAUSE: assert property (fwd_valid |-> $past(i2c_req))
      else $error("forward without request");
   AST_RW_KEPT: assert property (
      fwd_valid |-> fwd_byte[0] == $past(i2c_first_byte[0]))
      else $error("rw bit changed");
   AST_ALIAS_ZERO: assert property (
      i2c_req && i2c_first_byte[7:1] == 7'h00 |=> !fwd_valid)
      else $error("zero address forwarded");
   AST_ACK_WRITE: assert property (
      fwd_auto_ack |-> $past(i2c_req && !i2c_first_byte[0]))
      else $error("auto ack without write");
   AST_GPIO_STILL: assert property (
      !fc_load && !reg_wr |=> $stable(link_gpio_count))
      else $error("gpio count moved");
   AST_FWD_HOLD: assert property (!fwd_valid |-> $stable(fwd_byte))
      else $error("forward byte moved");
   AST_RD_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved");
   AST_UNMAPPED: assert property (
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind rlar_top rlar_checker #(.NPORTS(NPORTS)) i_chk (.*);

//--- tb/rlar_ser_model.sv
`timescale 1ns/10ps
module rlar_ser_model
(
   input wire logic core_clk,
   output logic fc_load,
   output logic fc_port,
   output logic [1:0] fc_gpio_count,
   output logic fc_id_load,
   output logic [6:0] fc_id
);
   initial {fc_load, fc_port, fc_gpio_count, fc_id_load, fc_id} = '0;
   // One load pulse, then values scrambled
   task automatic send(input logic id, input logic p, input logic [6:0] v);
      @(negedge core_clk);
      fc_port = p;
      fc_load = !id;
      fc_id_load = id;
      fc_gpio_count = v[1:0];
      fc_id = v;
      @(negedge core_clk);
      fc_load = 1'b0;
      fc_id_load = 1'b0;
      fc_gpio_count = ~fc_gpio_count;
      fc_id = ~fc_id;
   endtask
endmodule

//--- tb/test_remote_link_id_and_alias_regs.sv
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_remote_link_id_and_alias_regs;
   logic core_clk, rst_b, reg_wr, reg_rd, i2c_req, i2c_port, fc_load, fc_id_load;
   logic fwd_valid, fwd_auto_ack, fc_port;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, i2c_first_byte, fwd_byte;
   logic [1:0] fc_gpio_count;
   logic [6:0] fc_id;
   logic [3:0] link_gpio_count;
   logic [7:0] adr [7] = '{8'h4c, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d};
   int miscompares = 0;
   int cmp_count = 0;
   rlar_top #(.NPORTS(2)) i_dut (.*);
   rlar_ser_model i_ser (.*);
   always #20 core_clk = ~core_clk;
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      @(negedge core_clk);
      `CHK(reg_rdata, e)
   endtask
   task automatic req(input logic p, input logic [7:0] b, input logic v, input logic [7:0] f,
      input logic k);
      @(negedge core_clk);
      i2c_req = 1'b1;
      i2c_port = p;
      i2c_first_byte = b;
      @(negedge core_clk);
      i2c_req = 1'b0;
      `CHK(fwd_valid, v)
      if (v) `CHK(fwd_byte, f)
      `CHK(fwd_auto_ack, k)
   endtask
   initial
   begin
      repeat (2000) @(posedge core_clk);
      miscompares++;
      complete_run();
   end
   initial
   begin
      {core_clk, rst_b, reg_wr, reg_rd, i2c_req, i2c_port} = '0;
      {reg_addr, reg_wdata, i2c_first_byte} = '0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rst_b = 1'b1;
      foreach (adr[i]) rd(adr[i], 8'h00);
      i_ser.send(0, 0, 7'h03);
      `CHK(link_gpio_count[1:0], 2'h3)
      wr(8'h59, 8'h81);
      `CHK(link_gpio_count[1:0], 2'h3)
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h59, 8'h80 | c[7:0]);
         `CHK(link_gpio_count[1:0], c[1:0])
      end
      i_ser.send(0, 0, 7'h01);
      `CHK(link_gpio_count[1:0], 2'h3)
      wr(8'h59, 8'h00);
      i_ser.send(0, 0, 7'h02);
      `CHK(link_gpio_count, 4'h2)
      i_ser.send(1, 0, 7'h55);
      rd(8'h5b, 8'haa);
      wr(8'h5b, 8'h25);
      i_ser.send(1, 0, 7'h33);
      rd(8'h5b, 8'h25);
      wr(8'h4c, 8'h01);
      wr(8'h5c, 8'h61);
      rd(8'h5c, 8'h61);
      rd(8'h5b, 8'h00);
      wr(8'h4c, 8'h00);
      rd(8'h00, 8'h00);
      wr(8'h5d, 8'ha0);
      wr(8'h65, 8'h80);
      wr(8'h58, 8'h40);
      req(0, 8'h00, 0, 8'h00, 0);
      wr(8'h5c, 8'h61);
      req(0, 8'h60, 1, 8'ha0, 1);
      req(0, 8'h61, 1, 8'ha1, 0);
      req(0, 8'h81, 1, 8'ha1, 0);
      req(0, 8'h62, 0, 8'h00, 0);
      req(1, 8'h60, 0, 8'h00, 1);
      wr(8'h58, 8'h00);
      req(0, 8'h60, 0, 8'h00, 1);
      // Mid-run reset clears override and alias, link load allowed again
      wr(8'h59, 8'h80);
      @(negedge core_clk);
      rst_b = 1'b0;
      @(negedge core_clk);
      rst_b = 1'b1;
      rd(8'h59, 8'h00);
      rd(8'h5c, 8'h00);
      i_ser.send(0, 0, 7'h01);
      `CHK(link_gpio_count, 4'h1)
      complete_run();
   end
endmodule
